// [hw/pbcsr_pkg.sv]
`default_nettype none
package pbcsr_pkg;
    // Management addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STAT = 5'h01;
    // Frame opcodes
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    // Frame field lengths, counted from zero
    localparam logic [4:0] HDR_LAST = 5'h0C;
    localparam logic [4:0] TA_LAST = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    // Control bit positions
    localparam int CTRL_RESET = 15;
    localparam int CTRL_LOOP = 14;
    localparam int CTRL_SPD_LSB = 13;
    localparam int CTRL_AN_EN = 12;
    localparam int CTRL_PDOWN = 11;
    localparam int CTRL_ISO = 10;
    localparam int CTRL_AN_RST = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_COLT = 7;
    localparam int CTRL_SPD_MSB = 6;
    localparam logic [15:0] CTRL_RST_VAL = 16'h3000;
    localparam logic [15:0] CTRL_WR_MASK = 16'hFFC0;
    // Status bit positions
    localparam int STAT_AN_DONE = 5;
    localparam int STAT_RFAULT = 4;
    localparam int STAT_LINK = 2;
    localparam int STAT_JABBER = 1;
    localparam logic [15:0] STAT_FIXED = 16'h7949;
    // Speed codes {msb, lsb}
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    // Software reset hold time
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RST_NS = 1000;
    localparam int SOFT_RST_CYC = SOFT_RST_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SOFT_RST_LOAD = 8'(SOFT_RST_CYC - 1);

    function automatic logic spd_code_ok(input logic [1:0] code);
        spd_code_ok = (code == SPD_10) || (code == SPD_100);
    endfunction : spd_code_ok

    typedef enum logic [2:0] {
        SM_IDLE,
        SM_HDR,
        SM_TA,
        SM_DATA
    } pbcsr_sm_t;
endpackage : pbcsr_pkg
`default_nettype wire

// [hw/pbcsr_mgmt_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pbcsr_mgmt_if;
    logic wr_stb;
    logic rd_stb;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport port_side (
        output wr_stb,
        output rd_stb,
        output addr,
        output wdata,
        input rdata
    );
    modport reg_side (
        input wr_stb,
        input rd_stb,
        input addr,
        input wdata,
        output rdata
    );
endinterface : pbcsr_mgmt_if
`default_nettype wire

// [hw/pbcsr_latch_bit.sv]
`timescale 1ns/10ps
`default_nettype none
module pbcsr_latch_bit #(
    parameter bit LATCH_HIGH = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clr,
    input wire logic i_cond,
    input wire logic i_rd,
    output logic o_val
);
    logic val_ff;
    logic nxt_val;

    // A condition present during the read keeps the bit latched
    always_comb
    begin
        if (LATCH_HIGH)
            nxt_val = i_cond | (val_ff & ~i_rd);
        else
            nxt_val = i_cond & (val_ff | i_rd);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_clr)
            val_ff <= 1'b0;
        else
            val_ff <= nxt_val;
    end

    assign o_val = val_ff;
endmodule : pbcsr_latch_bit
`default_nettype wire

// [hw/pbcsr_serial_management_port.sv]
`timescale 1ns/10ps
`default_nettype none
module pbcsr_serial_management_port
    import pbcsr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [4:0] i_phy_addr,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    pbcsr_mgmt_if.port_side mgmt
);
    pbcsr_sm_t state_ff;
    logic mdc_ff;
    logic [4:0] cnt_ff;
    logic [11:0] hdr_ff;
    logic [15:0] sh_ff;
    logic rd_ff;
    logic mine_ff;
    logic [4:0] reg_ff;
    logic wr_stb_ff;
    logic rd_stb_ff;
    logic [15:0] wdata_ff;
    logic out_ff;
    logic oe_ff;
    logic rise;
    logic [12:0] hdr_all;

    assign rise = i_mdc & ~mdc_ff;
    assign hdr_all = {hdr_ff, i_mdio};

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            mdc_ff <= 1'b0;
        else
            mdc_ff <= i_mdc;
    end

    // Frame sequencer; no preamble needed, first zero is start
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_ff <= SM_IDLE;
            cnt_ff <= 5'h00;
            hdr_ff <= 12'h000;
            rd_ff <= 1'b0;
            mine_ff <= 1'b0;
            reg_ff <= 5'h00;
        end
        else if (rise)
        begin
            cnt_ff <= cnt_ff + 5'h01;
            case (state_ff)
                SM_IDLE:
                begin
                    cnt_ff <= 5'h00;
                    if (!i_mdio)
                        state_ff <= SM_HDR;
                end
                SM_HDR:
                begin
                    hdr_ff <= hdr_all[11:0];
                    if (cnt_ff == HDR_LAST)
                    begin
                        cnt_ff <= 5'h00;
                        rd_ff <= (hdr_all[11:10] == OP_READ);
                        mine_ff <= (hdr_all[9:5] == i_phy_addr) &&
                            ((hdr_all[11:10] == OP_READ) ||
                             (hdr_all[11:10] == OP_WRITE));
                        reg_ff <= hdr_all[4:0];
                        state_ff <= hdr_all[12] ? SM_TA : SM_IDLE;
                    end
                end
                SM_TA:
                begin
                    if (cnt_ff == TA_LAST)
                    begin
                        cnt_ff <= 5'h00;
                        state_ff <= SM_DATA;
                    end
                end
                SM_DATA:
                begin
                    if (cnt_ff == DATA_LAST)
                        state_ff <= SM_IDLE;
                end
                default:
                    state_ff <= SM_IDLE;
            endcase
        end
    end

    // Read strobe one cycle after the header; data captured with it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            rd_stb_ff <= 1'b0;
        else
            rd_stb_ff <= rise && state_ff == SM_HDR &&
                cnt_ff == HDR_LAST && hdr_all[12] &&
                hdr_all[11:10] == OP_READ &&
                hdr_all[9:5] == i_phy_addr;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_stb_ff <= 1'b0;
            wdata_ff <= 16'h0000;
        end
        else
        begin
            wr_stb_ff <= rise && state_ff == SM_DATA &&
                cnt_ff == DATA_LAST && mine_ff && !rd_ff;
            if (rise && state_ff == SM_DATA && cnt_ff == DATA_LAST)
                wdata_ff <= {sh_ff[14:0], i_mdio};
        end
    end

    // Shift register and pin drive; host samples on rising edges
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sh_ff <= 16'h0000;
            out_ff <= 1'b1;
            oe_ff <= 1'b0;
        end
        else if (rd_stb_ff)
            sh_ff <= mgmt.rdata;
        else if (rise)
        begin
            if (state_ff == SM_TA && mine_ff && rd_ff)
            begin
                oe_ff <= 1'b1;
                out_ff <= (cnt_ff == TA_LAST) ? sh_ff[15] : 1'b0;
                if (cnt_ff == TA_LAST)
                    sh_ff <= {sh_ff[14:0], 1'b0};
            end
            else if (state_ff == SM_DATA && rd_ff)
            begin
                out_ff <= sh_ff[15];
                sh_ff <= {sh_ff[14:0], 1'b0};
                if (cnt_ff == DATA_LAST)
                    oe_ff <= 1'b0;
            end
            else if (state_ff == SM_DATA)
                sh_ff <= {sh_ff[14:0], i_mdio};
            else
                oe_ff <= 1'b0;
        end
    end

    assign mgmt.wr_stb = wr_stb_ff;
    assign mgmt.rd_stb = rd_stb_ff;
    assign mgmt.addr = reg_ff;
    assign mgmt.wdata = wdata_ff;
    assign o_mdio = out_ff;
    assign o_mdio_oe = oe_ff;
endmodule : pbcsr_serial_management_port
`default_nettype wire

// [hw/pbcsr_top.sv]
// Functional notes
// RULE1: Writing reset bit restores register defaults, then the bit self-clears.
// RULE2: Host waits one microsecond after setting reset before next access.
// RULE3: Loopback bit loops data back at current speed and duplex.
// RULE4: Speed code {bit6,bit13}: 00 is 10M, 01 is 100M, rest reserved.
// RULE5: Bit 12 enables auto-negotiation; resets to one.
// RULE6: Bit 11 puts the device in power-down; resets to zero.
// RULE7: Bit 10 disables MAC-side outputs and ignores MAC-side inputs.
// RULE8: Writing one to bit 9 restarts auto-negotiation; bit self-clears.
// RULE9: Bit 8 selects full duplex when one, half when zero.
// RULE10: Bit 7 enables collision test; resets to zero.
// RULE11: Status 15..9 show fixed capabilities, TX and 10T modes only.
// RULE12: Status bit 8 always one, extended status present.
// RULE13: Status bit 6 one, frames accepted without preamble.
// RULE14: Status bit 4 latches high on far-end fault until read.
// RULE15: Status bit 2 shows link, latches low on loss until read.
// RULE16: Status bit 1 latches high on jabber.
// RULE17: Status bit 0 always one, extended registers present.
// RULE18: Host keeps page select at zero before accessing control.
// RULE19: Host polls control until reset bit reads zero.
// RULE20: Read-only bits ignore writes; status read releases ended latches.
// RULE21: Status bit 5 shows negotiation done; bit 3 always one.
`timescale 1ns/10ps
`default_nettype none
module pbcsr_top
    import pbcsr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [4:0] i_phy_addr,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe,
    input wire logic i_link_up,
    input wire logic i_remote_fault,
    input wire logic i_jabber,
    input wire logic i_an_complete,
    input wire logic i_mac_tx_en,
    input wire logic i_line_rx_dv,
    output logic o_line_tx_en,
    output logic o_mac_rx_dv,
    output logic o_mac_out_en,
    output logic o_loopback,
    output logic o_speed_100,
    output logic o_full_duplex,
    output logic o_an_enable,
    output logic o_an_restart,
    output logic o_power_down,
    output logic o_isolate,
    output logic o_col_test,
    output logic o_soft_reset
);
    pbcsr_mgmt_if mgmt ();

    logic [15:0] ctrl_ff;
    logic [7:0] srst_cnt_ff;
    logic speed_100_ff;
    logic an_restart_ff;
    logic line_tx_en_ff;
    logic mac_rx_dv_ff;
    logic mac_out_en_ff;
    logic rfault;
    logic link;
    logic jabber;
    logic stat_rd;
    logic ctrl_wr;
    logic srst_busy;
    logic srst_done;
    logic srst_start;
    logic [1:0] spd_code;
    logic [15:0] stat_val;
    logic [15:0] rdata;

    pbcsr_serial_management_port u_port (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_phy_addr(i_phy_addr),
        .i_mdc(i_mdc),
        .i_mdio(i_mdio),
        .o_mdio(o_mdio),
        .o_mdio_oe(o_mdio_oe),
        .mgmt(mgmt.port_side)
    );

    // Strobe qualified by one register address
    function automatic logic reg_hit(input logic stb, input logic [4:0] a,
        input logic [4:0] target);
        reg_hit = stb && (a == target);
    endfunction : reg_hit

    assign srst_busy = ctrl_ff[CTRL_RESET];
    assign srst_done = srst_busy && (srst_cnt_ff == 8'h00);
    // Writes during the reset hold are dropped; host should wait
    assign ctrl_wr = reg_hit(mgmt.wr_stb, mgmt.addr, ADDR_CTRL) &&
        !srst_busy; // RULE2
    assign srst_start = ctrl_wr && mgmt.wdata[CTRL_RESET];
    assign stat_rd = reg_hit(mgmt.rd_stb, mgmt.addr, ADDR_STAT);
    assign spd_code = {ctrl_ff[CTRL_SPD_MSB], ctrl_ff[CTRL_SPD_LSB]};

    // Control register; reset bit set starts the hold
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ctrl_ff <= CTRL_RST_VAL;
        else if (srst_busy)
        begin
            ctrl_ff <= CTRL_RST_VAL; // RULE1
            ctrl_ff[CTRL_RESET] <= !srst_done; // RULE1
        end
        else if (srst_start)
        begin
            ctrl_ff <= CTRL_RST_VAL; // RULE1
            ctrl_ff[CTRL_RESET] <= 1'b1;
        end
        else if (ctrl_wr)
            ctrl_ff <= mgmt.wdata & CTRL_WR_MASK; // RULE20
        else
            ctrl_ff[CTRL_AN_RST] <= 1'b0; // RULE8
    end

    // Hold counter for the software reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            srst_cnt_ff <= 8'h00;
        else if (srst_start)
            srst_cnt_ff <= SOFT_RST_LOAD; // RULE1
        else if (srst_busy && srst_cnt_ff != 8'h00)
            srst_cnt_ff <= srst_cnt_ff - 8'h01;
    end

    // Reserved codes keep the last valid speed
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            speed_100_ff <= 1'b1;
        else if (spd_code_ok(spd_code))
            speed_100_ff <= (spd_code == SPD_100); // RULE4
    end

    // One-cycle restart pulse toward the negotiation engine
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            an_restart_ff <= 1'b0;
        else
            an_restart_ff <= ctrl_ff[CTRL_AN_RST]; // RULE8
    end

    // Latched status; cleared by either reset since none are sticky
    pbcsr_latch_bit #(
        .LATCH_HIGH(1'b1)
    ) u_rfault (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(srst_busy),
        .i_cond(i_remote_fault),
        .i_rd(stat_rd),
        .o_val(rfault)
    ); // RULE14

    pbcsr_latch_bit #(
        .LATCH_HIGH(1'b0)
    ) u_link (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(srst_busy),
        .i_cond(i_link_up),
        .i_rd(stat_rd),
        .o_val(link)
    ); // RULE15

    pbcsr_latch_bit #(
        .LATCH_HIGH(1'b1)
    ) u_jabber (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(srst_busy),
        .i_cond(i_jabber),
        .i_rd(stat_rd),
        .o_val(jabber)
    ); // RULE16

    // Status word; fixed bits come from one constant
    always_comb
    begin
        stat_val = STAT_FIXED; // RULE11 RULE12 RULE13 RULE17 RULE21
        stat_val[STAT_AN_DONE] = i_an_complete; // RULE21
        stat_val[STAT_RFAULT] = rfault; // RULE14
        stat_val[STAT_LINK] = link; // RULE15
        stat_val[STAT_JABBER] = jabber; // RULE16
    end

    // Other addresses read zero
    always_comb
    begin
        case (mgmt.addr)
            ADDR_CTRL:
                rdata = ctrl_ff;
            ADDR_STAT:
                rdata = stat_val;
            default:
                rdata = 16'h0000;
        endcase
    end

    assign mgmt.rdata = rdata;

    // MAC-side gating; loopback turns transmit back to receive
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            mac_out_en_ff <= !CTRL_RST_VAL[CTRL_ISO];
        else
            mac_out_en_ff <= !ctrl_ff[CTRL_ISO]; // RULE7
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            line_tx_en_ff <= 1'b0;
        else
            line_tx_en_ff <= i_mac_tx_en && !ctrl_ff[CTRL_ISO] &&
                !ctrl_ff[CTRL_PDOWN] && !ctrl_ff[CTRL_LOOP]; // RULE7
    end

    // Isolate and power-down outrank loopback
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            mac_rx_dv_ff <= 1'b0;
        else if (ctrl_ff[CTRL_ISO] || ctrl_ff[CTRL_PDOWN])
            mac_rx_dv_ff <= 1'b0; // RULE6 RULE7
        else if (ctrl_ff[CTRL_LOOP])
            mac_rx_dv_ff <= i_mac_tx_en; // RULE3
        else
            mac_rx_dv_ff <= i_line_rx_dv;
    end

    // Mode outputs toward the datapath
    // Reset values follow the control default so both resets agree
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_loopback <= CTRL_RST_VAL[CTRL_LOOP];
        else
            o_loopback <= ctrl_ff[CTRL_LOOP]; // RULE3
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_full_duplex <= CTRL_RST_VAL[CTRL_DUPLEX];
        else
            o_full_duplex <= ctrl_ff[CTRL_DUPLEX]; // RULE9
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_an_enable <= CTRL_RST_VAL[CTRL_AN_EN];
        else
            o_an_enable <= ctrl_ff[CTRL_AN_EN]; // RULE5
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_power_down <= CTRL_RST_VAL[CTRL_PDOWN];
        else
            o_power_down <= ctrl_ff[CTRL_PDOWN]; // RULE6
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_isolate <= CTRL_RST_VAL[CTRL_ISO];
        else
            o_isolate <= ctrl_ff[CTRL_ISO]; // RULE7
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_col_test <= CTRL_RST_VAL[CTRL_COLT];
        else
            o_col_test <= ctrl_ff[CTRL_COLT]; // RULE10
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_soft_reset <= CTRL_RST_VAL[CTRL_RESET];
        else
            o_soft_reset <= srst_busy; // RULE1
    end

    assign o_speed_100 = speed_100_ff;
    assign o_an_restart = an_restart_ff;
    assign o_line_tx_en = line_tx_en_ff;
    assign o_mac_rx_dv = mac_rx_dv_ff;
    assign o_mac_out_en = mac_out_en_ff;
endmodule : pbcsr_top
`default_nettype wire

// [tb/pbcsr_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module pbcsr_checker
    import pbcsr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_mac_tx_en,
    input wire logic i_line_rx_dv,
    input wire logic o_line_tx_en,
    input wire logic o_mac_rx_dv,
    input wire logic o_mac_out_en,
    input wire logic o_loopback,
    input wire logic o_speed_100,
    input wire logic o_full_duplex,
    input wire logic o_an_enable,
    input wire logic o_an_restart,
    input wire logic o_power_down,
    input wire logic o_isolate,
    input wire logic o_col_test,
    input wire logic o_soft_reset
);
    logic [7:0] srst_cnt_ff;
    wire logic [2:0] cfg;
    assign cfg = {o_isolate, o_power_down, o_loopback};
    // Counts hold cycles of the software reset
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !o_soft_reset)
            srst_cnt_ff <= 8'h00;
        else
            srst_cnt_ff <= srst_cnt_ff + 8'h01;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Path checks wait for settled config, away from reset
    sequence s_cfg_quiet;
        (!$past(i_rst) && $stable(cfg)) [*3];
    endsequence
    sequence s_srst_held;
        o_soft_reset ##1 o_soft_reset;
    endsequence
    property p_line_tx;
        s_cfg_quiet |-> o_line_tx_en == ($past(i_mac_tx_en) && cfg == 3'h0);
    endproperty
    a_line_tx: assert property (p_line_tx)
        else $error("line tx enable wrong");
    property p_mac_rx;
        s_cfg_quiet |-> o_mac_rx_dv == ((cfg[2:1] != 2'h0) ? 1'b0 :
            (cfg[0] ? $past(i_mac_tx_en) : $past(i_line_rx_dv)));
    endproperty
    a_mac_rx: assert property (p_mac_rx)
        else $error("mac rx valid wrong");
    property p_out_en;
        s_cfg_quiet |-> o_mac_out_en == !o_isolate;
    endproperty
    a_out_en: assert property (p_out_en)
        else $error("mac output enable wrong");
    property p_iso_quiet;
        o_isolate ##1 o_isolate |-> !o_mac_out_en && !o_mac_rx_dv;
    endproperty
    a_iso_quiet: assert property (p_iso_quiet)
        else $error("isolated outputs active");
    property p_an_pulse;
        o_an_restart |=> !o_an_restart [*4];
    endproperty
    a_an_pulse: assert property (p_an_pulse)
        else $error("restart not self clearing");
    property p_srst_len;
        $fell(o_soft_reset) |-> srst_cnt_ff == 8'(SOFT_RST_CYC);
    endproperty
    a_srst_len: assert property (p_srst_len)
        else $error("soft reset hold length wrong");
    property p_srst_dflt;
        s_srst_held |-> o_an_enable && o_speed_100 && !o_loopback &&
            !o_power_down && !o_isolate && !o_col_test && !o_full_duplex;
    endproperty
    a_srst_dflt: assert property (p_srst_dflt)
        else $error("soft reset left non-default control");
    property p_rst_vals;
        $fell(i_rst) |-> o_an_enable && o_speed_100 && o_mac_out_en &&
            !o_power_down && !o_col_test && !o_full_duplex && !o_soft_reset;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("reset control outputs wrong");
endmodule : pbcsr_checker
bind pbcsr_top pbcsr_checker u_chk (.*);
`default_nettype wire

// [tb/pbcsr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pbcsr_host_model
    import pbcsr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_mdio,
    output logic o_mdc,
    output logic o_mdio,
    output logic o_mdio_oe
);
    initial
    begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end
    // No preamble sent; page select left at zero
    // Four cycles per half period keeps above the three-cycle minimum
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
        input logic [4:0] ra, input logic [15:0] wd,
        output logic [15:0] rd);
        logic [31:0] f;
        f = {2'b01, op, phy, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge i_clk);
            o_mdc <= 1'b0;
            o_mdio_oe <= (op == OP_WRITE) || (i < 14);
            o_mdio <= f[31 - i];
            repeat (4) @(posedge i_clk);
            o_mdc <= 1'b1;
            if (i >= 16)
                rd = {rd[14:0], i_mdio};
            repeat (3) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_mdc <= 1'b0;
        o_mdio_oe <= 1'b0;
    endtask : xfer
endmodule : pbcsr_host_model
`default_nettype wire

// [tb/tb_pbcsr_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_pbcsr_top;
    import pbcsr_pkg::*;
    localparam logic [4:0] PHY = 5'h05;
    logic i_clk, i_rst, i_mdc, o_mdio, o_mdio_oe, i_link_up, i_remote_fault;
    logic i_jabber, i_an_complete, o_line_tx_en;
    logic i_mac_tx_en = 1'b0;
    logic i_line_rx_dv = 1'b0;
    logic o_mac_rx_dv, o_mac_out_en, o_loopback, o_speed_100, o_full_duplex;
    logic o_an_enable, o_an_restart, o_power_down, o_isolate, o_col_test;
    logic o_soft_reset, h_mdio, h_oe, sp_exp;
    logic [4:0] i_phy_addr;
    logic [15:0] rd, st;
    // Code 10 after a 100M entry shows the hold from the other side
    logic [15:0] wtab [5] = '{16'h45BF, 16'h3A40, 16'h6100, 16'h0040,
        16'h2000};
    wire logic i_mdio;
    wire logic [6:0] flags;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_restart = 0;
    int k;
    // Line has a pull-up, so a released mdio reads one
    assign i_mdio = o_mdio_oe ? o_mdio : (h_oe ? h_mdio : 1'b1);
    assign flags = {o_loopback, o_speed_100, o_full_duplex, o_an_enable,
        o_power_down, o_isolate, o_col_test};
    pbcsr_top uut (.*);
    pbcsr_host_model host (.i_clk(i_clk), .i_mdio(i_mdio), .o_mdc(i_mdc),
        .o_mdio(h_mdio), .o_mdio_oe(h_oe));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        i_mac_tx_en <= ~i_mac_tx_en;
        i_line_rx_dv <= i_mac_tx_en ~^ i_line_rx_dv;
        if (o_an_restart === 1'b1)
            n_restart <= n_restart + 1;
    end
    task automatic give_verdict;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] d;
        host.xfer(OP_READ, PHY, ra, 16'h0000, d);
        check(d, exp);
    endtask : rd_reg
    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
        logic [15:0] d;
        host.xfer(OP_WRITE, PHY, ra, wd, d);
        repeat (2) @(posedge i_clk);
    endtask : wr_reg
    // Reserved speed codes leave the speed output unchanged
    task automatic cfg(input logic [15:0] wd);
        logic [15:0] c;
        c = wd & CTRL_WR_MASK & 16'h7DFF;
        if ({wd[6], wd[13]} == SPD_10)
            sp_exp = 1'b0;
        else if ({wd[6], wd[13]} == SPD_100)
            sp_exp = 1'b1;
        wr_reg(ADDR_CTRL, wd);
        check({9'h000, flags},
            {9'h000, c[14], sp_exp, c[8], c[12], c[11], c[10], c[7]});
        rd_reg(ADDR_CTRL, c);
    endtask : cfg
    initial
    begin
        repeat (50000) @(posedge i_clk);
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        i_rst = 1'b1;
        i_phy_addr = PHY;
        i_link_up = 1'b0;
        i_remote_fault = 1'b0;
        i_jabber = 1'b0;
        i_an_complete = 1'b0;
        sp_exp = 1'b1;
        st = STAT_FIXED | 16'h0020;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        check({9'h000, flags}, 16'h0028);
        rd_reg(ADDR_CTRL, CTRL_RST_VAL);
        rd_reg(ADDR_STAT, STAT_FIXED);
        foreach (wtab[i])
            cfg(wtab[i]);
        check(16'(n_restart), 16'h0001);
        i_link_up <= 1'b1;
        i_an_complete <= 1'b1;
        rd_reg(ADDR_STAT, st);
        rd_reg(ADDR_STAT, st | 16'h0004);
        i_remote_fault <= 1'b1;
        i_jabber <= 1'b1;
        i_link_up <= 1'b0;
        @(posedge i_clk);
        i_remote_fault <= 1'b0;
        i_jabber <= 1'b0;
        i_link_up <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd_reg(ADDR_STAT, st | 16'h0012);
        rd_reg(ADDR_STAT, st | 16'h0004);
        wr_reg(ADDR_STAT, 16'h0000);
        rd_reg(ADDR_STAT, st | 16'h0004);
        rd_reg(5'h02, 16'h0000);
        host.xfer(OP_WRITE, PHY + 5'h01, ADDR_CTRL, 16'h0800, rd);
        host.xfer(OP_READ, PHY + 5'h01, ADDR_CTRL, 16'h0000, rd);
        check(rd, 16'hFFFF);
        rd_reg(ADDR_CTRL, 16'h2000);
        wr_reg(ADDR_CTRL, 16'h4D80);
        i_remote_fault <= 1'b1;
        @(posedge i_clk);
        i_remote_fault <= 1'b0;
        wr_reg(ADDR_CTRL, 16'h8000);
        repeat (SOFT_RST_CYC) @(posedge i_clk);
        k = 0;
        rd = 16'hFFFF;
        while (rd[15] !== 1'b0)
        begin
            host.xfer(OP_READ, PHY, ADDR_CTRL, 16'h0000, rd);
            k++;
            if (k > 8)
            begin
                n_mismatch++;
                give_verdict();
            end
        end
        check(rd, CTRL_RST_VAL);
        check({9'h000, flags}, 16'h0028);
        rd_reg(ADDR_STAT, st);
        give_verdict();
    end
endmodule : tb_pbcsr_top
`default_nettype wire
